// file: design/port1_phy_regs.sv
// Port 1 PHY control and status registers with event interrupt.
// Assumes transceiver status arrives asynchronously; indicator
// activity comes from logic on clk_sys.
//
// What this block does
// - Control bit 15 drives all indicators high
// - Control bit 14 disables the transmitter
// - Writing one to bit 13 restarts negotiation
// - Bit 12 stops far-end-fault detect and send
// - Bit 11 powers the transceiver down
// - Bit 10 turns off automatic crossover
// - Bit 9 forces MDI-X when crossover off
// - Bit 8 enables far-end loopback via port 1
// - Bit 7 enables negotiation, resets to one
// - Negotiation off: bit 6 picks 100 or 10
// - Negotiation off or failed: bit 5 duplex
// - Bits 4..0 advertise abilities, reset to one
// - Status bit 15 writable crossover algorithm select
// - Status bit 13 shows reversed receive polarity
// - Status bits 12, 11 show flow control
// - Status bits 10, 9 show speed, duplex
// - Status bit 8 shows far-end fault
// - Status bits 4..0 show partner abilities
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module port1_phy_regs (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] indicatorActivity,
  input wire port1_phy_pkg::linkIn_t linkStatus,
  output logic portOneIndicator0,
  output logic portOneIndicator1,
  output logic portOneIndicator2,
  output logic portOneIndicator3,
  output logic txDisable,
  output logic anRestart,
  output logic fefDisable,
  output logic powerDown,
  output logic autoMdixOff,
  output logic forceMdix,
  output logic farEndLoopback,
  output logic anEnable,
  output logic forceSpeed100,
  output logic forceDuplexFull,
  output logic [4:0] advertise,
  output logic crossoverAlgorithmSelect,
  output logic resolvedSpeed100,
  output logic resolvedDuplexFull,
  output logic irq
);

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef struct packed {
    logic [15:0] ctl;
    logic xoverSel;
    logic [3:0] ind;
    logic anPulse;
    logic forceMdix;
    logic speed;
    logic duplex;
    logic fef;
    logic [4:0] partner;
    logic polarity;
    logic rxFlow;
    logic txFlow;
    logic [port1_phy_pkg::EV_W-1:0] intSts;
    logic [port1_phy_pkg::EV_W-1:0] intMask;
    logic irq;
  } regState_t;

  localparam regState_t STATE_RESET = '{
    ctl: port1_phy_pkg::CTL_RESET,
    xoverSel: port1_phy_pkg::XOVER_SEL_RESET,
    default: '0
  };

  regState_t stateReg;
  regState_t stateNext;
  port1_phy_pkg::regReq_t req;
  port1_phy_pkg::linkIn_t linkSync;
  logic [31:0] rdata;
  logic [15:0] stsWord;
  logic [port1_phy_pkg::EV_W-1:0] events;
  logic [port1_phy_pkg::EV_W-1:0] intClear;
  logic wrCtl;
  logic wrSts;
  logic anGood;

  // ---------------------------------------------
  // Bus front end and input synchroniser
  // ---------------------------------------------
  ahb_reg_port i_ahb_reg_port (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .rdata(rdata),
    .req(req),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  sync_bits #(
    .WIDTH($bits(port1_phy_pkg::linkIn_t))
  ) i_sync_bits (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(linkStatus),
    .dout(linkSync)
  );

  // ---------------------------------------------
  // Read view
  // ---------------------------------------------
  // Reserved bits and the omitted link bits read zero
  assign stsWord = {
    stateReg.xoverSel,
    1'b0,
    stateReg.polarity,
    stateReg.rxFlow,
    stateReg.txFlow,
    stateReg.speed,
    stateReg.duplex,
    stateReg.fef,
    3'h0,
    stateReg.partner
  };

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (req.index)
      port1_phy_pkg::CTL_IDX:
        rdata = {16'h0000, stateReg.ctl};
      port1_phy_pkg::STS_IDX:
        rdata = {16'h0000, stsWord};
      port1_phy_pkg::INT_STS_IDX:
        rdata[port1_phy_pkg::EV_W-1:0] = stateReg.intSts;
      port1_phy_pkg::INT_MASK_IDX:
        rdata[port1_phy_pkg::EV_W-1:0] = stateReg.intMask;
      default:
        rdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  assign wrCtl = req.valid && req.write && (req.index == port1_phy_pkg::CTL_IDX);
  assign wrSts = req.valid && req.write && (req.index == port1_phy_pkg::STS_IDX);
  assign intClear = (req.valid && req.write && (req.index == port1_phy_pkg::INT_STS_IDX))
    ? req.wdata[port1_phy_pkg::EV_W-1:0] : '0;
  // Negotiated duplex is trusted only once complete and not failed
  assign anGood = linkSync.anComplete && !linkSync.anFailed;

  always_comb
  begin
    stateNext = stateReg;
    events = '0;
    if (wrCtl)
      stateNext.ctl = req.wdata[15:0];
    if (wrSts)
      stateNext.xoverSel = req.wdata[port1_phy_pkg::STS_XOVER_SEL];
    if (req.valid && req.write && (req.index == port1_phy_pkg::INT_MASK_IDX))
      stateNext.intMask = req.wdata[port1_phy_pkg::EV_W-1:0];
    // One-cycle restart request on every write of a one
    stateNext.anPulse = wrCtl && req.wdata[port1_phy_pkg::CTL_AN_RESTART];
    stateNext.ind = stateReg.ctl[port1_phy_pkg::CTL_LED_OFF]
      ? port1_phy_pkg::IND_OFF : indicatorActivity;
    stateNext.forceMdix = stateReg.ctl[port1_phy_pkg::CTL_MDIX_OFF]
      && stateReg.ctl[port1_phy_pkg::CTL_FORCE_MDIX];
    stateNext.speed = stateReg.ctl[port1_phy_pkg::CTL_AN_EN]
      ? linkSync.anSpeed100 : stateReg.ctl[port1_phy_pkg::CTL_SPEED];
    stateNext.duplex = (stateReg.ctl[port1_phy_pkg::CTL_AN_EN] && anGood)
      ? linkSync.anDuplexFull : stateReg.ctl[port1_phy_pkg::CTL_DUPLEX];
    stateNext.fef = linkSync.farEndFault
      && !stateReg.ctl[port1_phy_pkg::CTL_FEF_DIS];
    stateNext.partner = linkSync.partnerAbility;
    stateNext.polarity = linkSync.polarityReversed;
    stateNext.rxFlow = linkSync.rxFlowActive;
    stateNext.txFlow = linkSync.txFlowActive;
    // Events compare the fresh status against the held copy
    events[port1_phy_pkg::EV_FEF] = stateNext.fef && !stateReg.fef;
    events[port1_phy_pkg::EV_SPEED_DUPLEX] = (stateNext.speed != stateReg.speed)
      || (stateNext.duplex != stateReg.duplex);
    events[port1_phy_pkg::EV_PARTNER] = stateNext.partner != stateReg.partner;
    events[port1_phy_pkg::EV_POLARITY] = stateNext.polarity && !stateReg.polarity;
    // Set wins over a clear in the same cycle
    stateNext.intSts = (stateReg.intSts & ~intClear) | events;
    stateNext.irq = |(stateNext.intSts & stateNext.intMask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      stateReg <= STATE_RESET;
    else
      stateReg <= stateNext;
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign portOneIndicator0 = stateReg.ind[0];
  assign portOneIndicator1 = stateReg.ind[1];
  assign portOneIndicator2 = stateReg.ind[2];
  assign portOneIndicator3 = stateReg.ind[3];
  assign txDisable = stateReg.ctl[port1_phy_pkg::CTL_TX_DIS];
  assign anRestart = stateReg.anPulse;
  assign fefDisable = stateReg.ctl[port1_phy_pkg::CTL_FEF_DIS];
  assign powerDown = stateReg.ctl[port1_phy_pkg::CTL_PWR_DOWN];
  assign autoMdixOff = stateReg.ctl[port1_phy_pkg::CTL_MDIX_OFF];
  assign forceMdix = stateReg.forceMdix;
  assign farEndLoopback = stateReg.ctl[port1_phy_pkg::CTL_FAR_LOOP];
  assign anEnable = stateReg.ctl[port1_phy_pkg::CTL_AN_EN];
  assign forceSpeed100 = stateReg.ctl[port1_phy_pkg::CTL_SPEED];
  assign forceDuplexFull = stateReg.ctl[port1_phy_pkg::CTL_DUPLEX];
  assign advertise = stateReg.ctl[4:0];
  assign crossoverAlgorithmSelect = stateReg.xoverSel;
  assign resolvedSpeed100 = stateReg.speed;
  assign resolvedDuplexFull = stateReg.duplex;
  assign irq = stateReg.irq;

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence sCtlWrite;
    wrCtl;
  endsequence

  sequence sStsWrite;
    wrSts;
  endsequence

  sequence sRestartPulse;
    anRestart ##1 !anRestart;
  endsequence

  AST_LED_OFF:
  assert property (stateReg.ctl[port1_phy_pkg::CTL_LED_OFF]
    |=> {portOneIndicator3, portOneIndicator2, portOneIndicator1, portOneIndicator0} == 4'hF)
  else $error("indicators not forced high");

  AST_TX_DISABLE:
  assert property (sCtlWrite |=> txDisable == $past(req.wdata[port1_phy_pkg::CTL_TX_DIS]))
  else $error("transmit disable does not follow write");

  AST_AN_RESTART:
  assert property (sCtlWrite ##0 req.wdata[port1_phy_pkg::CTL_AN_RESTART] |=> sRestartPulse)
  else $error("restart pulse missing or too long");

  AST_FEF_BLOCKED:
  assert property (fefDisable |=> !stsWord[8])
  else $error("far-end fault shown while disabled");

  AST_FORCE_MDIX:
  assert property (!autoMdixOff |=> !forceMdix)
  else $error("MDI-X forced with auto crossover on");

  AST_RESET_DEFAULTS:
  assert property ($rose(nrst) |-> stateReg.ctl == port1_phy_pkg::CTL_RESET
    && crossoverAlgorithmSelect == port1_phy_pkg::XOVER_SEL_RESET)
  else $error("wrong reset defaults");

  AST_FORCED_SPEED:
  assert property (!anEnable |=> resolvedSpeed100 == $past(forceSpeed100))
  else $error("forced speed not applied");

  AST_FORCED_DUPLEX:
  assert property ((!anEnable || linkSync.anFailed)
    |=> resolvedDuplexFull == $past(forceDuplexFull))
  else $error("forced duplex not applied");

  AST_STATUS_WRITE:
  assert property (sStsWrite ##0 req.wdata[14] |=> stsWord[15] == $past(req.wdata[15])
    && !stsWord[14] && stsWord[7:5] == 3'h0)
  else $error("status write touched read-only bits");

  AST_IRQ_LEVEL:
  assert property ((|(events & stateNext.intMask)) |=> irq)
  else $error("interrupt low with unmasked event");

  AST_EVENT_STICKY:
  assert property ((|events) |=> (stateReg.intSts & $past(events)) == $past(events))
  else $error("event lost to a clear");

  AST_MDIX_OFF:
  assert property (sCtlWrite
    |=> autoMdixOff == $past(req.wdata[port1_phy_pkg::CTL_MDIX_OFF]))
  else $error("auto crossover disable does not follow write");

  AST_POWER_DOWN:
  assert property (sCtlWrite
    |=> powerDown == $past(req.wdata[port1_phy_pkg::CTL_PWR_DOWN]))
  else $error("power-down does not follow write");

  AST_FAR_LOOP:
  assert property (sCtlWrite
    |=> farEndLoopback == $past(req.wdata[port1_phy_pkg::CTL_FAR_LOOP]))
  else $error("loopback does not follow write");

  AST_ADVERTISE:
  assert property (sCtlWrite |=> advertise == $past(req.wdata[4:0]))
  else $error("advertised abilities do not follow write");

  AST_AN_SPEED:
  assert property (anEnable |=> resolvedSpeed100 == $past(linkSync.anSpeed100))
  else $error("negotiated speed not applied");

  AST_AN_DUPLEX:
  assert property (anEnable && anGood
    |=> resolvedDuplexFull == $past(linkSync.anDuplexFull))
  else $error("negotiated duplex not applied");

  AST_LINK_MIRROR:
  assert property (nrst |=> stsWord[13] == $past(linkSync.polarityReversed)
    && stsWord[12] == $past(linkSync.rxFlowActive)
    && stsWord[11] == $past(linkSync.txFlowActive)
    && stsWord[4:0] == $past(linkSync.partnerAbility))
  else $error("status does not mirror link state");

  AST_FEF_SHOWN:
  assert property (!fefDisable |=> stsWord[8] == $past(linkSync.farEndFault))
  else $error("far-end fault not shown");

endmodule
`default_nettype wire

// file: pkg/port1_phy_pkg.sv
// Shared constants and carrier types for the port 1 PHY register pair.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package port1_phy_pkg;

  // ---------------------------------------------
  // Register indices; byte address is index * 4
  // ---------------------------------------------
  localparam logic [7:0] CTL_IDX = 8'h02;
  localparam logic [7:0] STS_IDX = 8'h04;
  localparam logic [7:0] INT_STS_IDX = 8'h06;
  localparam logic [7:0] INT_MASK_IDX = 8'h07;

  // ---------------------------------------------
  // Control register fields
  // ---------------------------------------------
  localparam int CTL_LED_OFF = 15;
  localparam int CTL_TX_DIS = 14;
  localparam int CTL_AN_RESTART = 13;
  localparam int CTL_FEF_DIS = 12;
  localparam int CTL_PWR_DOWN = 11;
  localparam int CTL_MDIX_OFF = 10;
  localparam int CTL_FORCE_MDIX = 9;
  localparam int CTL_FAR_LOOP = 8;
  localparam int CTL_AN_EN = 7;
  localparam int CTL_SPEED = 6;
  localparam int CTL_DUPLEX = 5;
  localparam logic [15:0] CTL_RESET = 16'h009F;

  // ---------------------------------------------
  // Status register fields
  // ---------------------------------------------
  localparam int STS_XOVER_SEL = 15;
  localparam logic XOVER_SEL_RESET = 1'h1;
  localparam logic [3:0] IND_OFF = 4'hF;

  // ---------------------------------------------
  // Interrupt events
  // ---------------------------------------------
  localparam int EV_W = 4;
  localparam int EV_FEF = 0;
  localparam int EV_SPEED_DUPLEX = 1;
  localparam int EV_PARTNER = 2;
  localparam int EV_POLARITY = 3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
    logic [31:0] wdata;
  } regReq_t;

  // Status reported by the transceiver, asynchronous to clk_sys
  typedef struct packed {
    logic polarityReversed;
    logic rxFlowActive;
    logic txFlowActive;
    logic anComplete;
    logic anFailed;
    logic anSpeed100;
    logic anDuplexFull;
    logic farEndFault;
    logic [4:0] partnerAbility;
  } linkIn_t;

endpackage

// file: design/sync_bits.sv
// Two-flop synchroniser for a group of independent level signals.
// Assumes each bit is a slow level; no word coherency is promised.
`timescale 1ns/10ps
`default_nettype none
module sync_bits #(
  parameter int WIDTH = 13
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } syncState_t;

  syncState_t stateReg;
  syncState_t stateNext;

  // First stage feeds only the second stage
  always_comb
  begin
    stateNext = stateReg;
    for (int i = 0; i < WIDTH; i++)
    begin
      stateNext.meta[i] = din[i];
      stateNext.held[i] = stateReg.meta[i];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  assign dout = stateReg.held;

endmodule
`default_nettype wire

// file: design/ahb_reg_port.sv
// AHB-Lite slave front end: one wait state per transfer.
// Assumes single word transfers; hresp is always OKAY.
`timescale 1ns/10ps
`default_nettype none
module ahb_reg_port (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rdata,
  output port1_phy_pkg::regReq_t req,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  typedef enum logic {IDLE, DATA} phase_t;

  typedef struct packed {
    phase_t phase;
    logic write;
    logic mapped;
    logic [7:0] index;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } portState_t;

  portState_t stateReg;
  portState_t stateNext;

  always_comb
  begin
    stateNext = stateReg;
    case (stateReg.phase)
      IDLE:
      begin
        if (hsel && htrans[1] && hready)
        begin
          stateNext.phase = DATA;
          stateNext.write = hwrite;
          stateNext.index = haddr[9:2];
          stateNext.mapped = (haddr[31:10] == 22'h00_0000);
          stateNext.ready = 1'b0;
        end
      end
      DATA:
      begin
        stateNext.phase = IDLE;
        stateNext.ready = 1'b1;
        if (!stateReg.write)
          stateNext.rdata = stateReg.mapped ? rdata : 32'h0000_0000;
      end
      default:
        stateNext.phase = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      stateReg <= '{phase: IDLE, ready: 1'b1, default: '0};
    else
      stateReg <= stateNext;
  end

  // Request stands for the whole data phase cycle
  assign req.valid = (stateReg.phase == DATA) && stateReg.mapped;
  assign req.write = stateReg.write;
  assign req.index = stateReg.index;
  assign req.wdata = hwdata;
  assign hrdata = stateReg.rdata;
  assign hreadyout = stateReg.ready;
  assign hresp = stateReg.resp;

endmodule
`default_nettype wire

// file: verif/link_partner_model.sv
// Stand-in for the link partner and transceiver status levels.
// Assumes the bench supplies the wanted status; changes land off the edge.
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
  input wire logic clk_sys,
  input wire port1_phy_pkg::linkIn_t want,
  output var port1_phy_pkg::linkIn_t linkStatus
);
  // Real status is asynchronous; a few ns of lag keeps it off the edge
  always @(posedge clk_sys)
    linkStatus <= #7 want;
endmodule
`default_nettype wire

// file: verif/tb_port1_phy_regs.sv
// Self-checking bench for the port 1 PHY control and status registers.
// Assumes a single AHB-Lite slave whose hreadyout feeds back as hready.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_port1_phy_regs;
  // ---------------------------------------------
  // Addresses
  // ---------------------------------------------
  localparam logic [31:0] CTL_A = {22'h0, port1_phy_pkg::CTL_IDX, 2'h0};
  localparam logic [31:0] STS_A = {22'h0, port1_phy_pkg::STS_IDX, 2'h0};
  localparam logic [31:0] INTS_A = {22'h0, port1_phy_pkg::INT_STS_IDX, 2'h0};
  localparam logic [31:0] MASK_A = {22'h0, port1_phy_pkg::INT_MASK_IDX, 2'h0};

  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] activity = 4'h0;
  port1_phy_pkg::linkIn_t want = '0;
  port1_phy_pkg::linkIn_t linkStatus;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, txDisable, anRestart, fefDisable, powerDown;
  logic ind0, ind1, ind2, ind3, autoMdixOff, forceMdix, farEndLoopback, anEnable;
  logic forceSpeed100, forceDuplexFull, crossoverAlgorithmSelect;
  logic resolvedSpeed100, resolvedDuplexFull;
  logic [4:0] advertise;
  logic [7:0] resetOuts;
  logic [11:0] ctlOuts;
  logic [8:0] ledOuts;
  int failCount = 0;
  int compares = 0;
  int restarts = 0;

  always #10 clk_sys = ~clk_sys;

  port1_phy_regs i_port1_phy_regs (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .indicatorActivity(activity), .linkStatus(linkStatus),
    .portOneIndicator0(ind0), .portOneIndicator1(ind1), .portOneIndicator2(ind2),
    .portOneIndicator3(ind3), .txDisable(txDisable), .anRestart(anRestart),
    .fefDisable(fefDisable), .powerDown(powerDown), .autoMdixOff(autoMdixOff),
    .forceMdix(forceMdix), .farEndLoopback(farEndLoopback), .anEnable(anEnable),
    .forceSpeed100(forceSpeed100), .forceDuplexFull(forceDuplexFull),
    .advertise(advertise), .crossoverAlgorithmSelect(crossoverAlgorithmSelect),
    .resolvedSpeed100(resolvedSpeed100), .resolvedDuplexFull(resolvedDuplexFull),
    .irq(irq)
  );

  link_partner_model i_link_partner_model (
    .clk_sys(clk_sys), .want(want), .linkStatus(linkStatus)
  );

  // Grouped outputs keep the checks short
  assign resetOuts = {anEnable, advertise, crossoverAlgorithmSelect, txDisable};
  assign ctlOuts = {txDisable, fefDisable, powerDown, autoMdixOff, forceMdix, farEndLoopback,
    anEnable, advertise};
  assign ledOuts = {ind3, ind2, ind1, ind0, forceMdix, autoMdixOff, resolvedSpeed100,
    resolvedDuplexFull, txDisable};

  // Restart is a one-cycle pulse, so each high cycle is one request
  always @(posedge clk_sys)
    if (anRestart === 1'b1)
      restarts++;

  // ---------------------------------------------
  // Bus tasks
  // ---------------------------------------------
  task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busXfer(1'b0, a, 32'h0000_0000, q);
    `CHK(nm, exp, q)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task giveVerdict;
    $display("Comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    settle(2);
    `CHK("reset outs", resetOuts, 8'hFE)
    rdChk("ctl reset", CTL_A, 32'h0000_009F);
    rdChk("status reset", STS_A, 32'h0000_8000);
    @(posedge clk_sys);
    activity <= 4'h5;
    settle(2);
    `CHK("indicators on", {ind3, ind2, ind1, ind0}, 4'h5)
    wr(CTL_A, 32'h0000_7F00);
    settle(2);
    `CHK("ctl outs", ctlOuts, 12'hFC0)
    `CHK("forced 10 half", {resolvedSpeed100, resolvedDuplexFull, forceSpeed100, forceDuplexFull}, 4'h0)
    `CHK("restart pulses", restarts, 1)
    rdChk("ctl readback", CTL_A, 32'h0000_7F00);
    wr(CTL_A, 32'h0000_8260);
    settle(2);
    `CHK("led off outs", ledOuts, 9'h1E6)
    wr(CTL_A, 32'h0000_2000);
    wr(CTL_A, 32'h0000_2000);
    settle(1);
    `CHK("restart pulses", restarts, 3)
    // Negotiated link: polarity, rx flow, 100 full, far-end fault
    @(posedge clk_sys);
    want <= 13'h1AF5;
    wr(CTL_A, 32'h0000_0080);
    settle(6);
    rdChk("status link", STS_A, 32'h0000_B715);
    `CHK("resolved link", {resolvedSpeed100, resolvedDuplexFull}, 2'h3)
    // Negotiation failed: duplex falls back to control bit 5
    @(posedge clk_sys);
    want <= 13'h17F5;
    settle(6);
    rdChk("status failed", STS_A, 32'h0000_AD15);
    wr(STS_A, 32'h0000_7FFF);
    settle(1);
    rdChk("status write", STS_A, 32'h0000_2D15);
    `CHK("xover select", crossoverAlgorithmSelect, 1'b0)
    // Interrupt: masked, unmasked, cleared, then a fresh fault edge
    rdChk("mask reset", MASK_A, 32'h0000_0000);
    `CHK("irq masked", irq, 1'b0)
    wr(MASK_A, 32'h0000_000F);
    settle(1);
    `CHK("irq unmasked", irq, 1'b1)
    wr(INTS_A, 32'h0000_000F);
    settle(1);
    `CHK("irq cleared", irq, 1'b0)
    wr(MASK_A, 32'h0000_0001);
    @(posedge clk_sys);
    want <= 13'h17D5;
    settle(6);
    `CHK("irq on fault fall", irq, 1'b0)
    @(posedge clk_sys);
    want <= 13'h17F5;
    settle(6);
    `CHK("irq on fault rise", irq, 1'b1)
    rdChk("int status", INTS_A, 32'h0000_0001);
    wr(INTS_A, 32'h0000_0001);
    settle(1);
    `CHK("irq after clear", irq, 1'b0)
    wr(32'h0000_000C, 32'hFFFF_FFFF);
    rdChk("unmapped", 32'h0000_000C, 32'h0000_0000);
    rdChk("out of range", 32'h0000_0400, 32'h0000_0000);
    `CHK("response", hresp, 1'b0)
    giveVerdict;
  end

  // Whole run is well under 2000 cycles; 10000 means a hung handshake
  initial
  begin
    #200000;
    failCount++;
    giveVerdict;
  end
endmodule
`default_nettype wire
